/* mgt_target.sv */
// Two-wire target port of the magnetometer: framing, address match, data
`timescale 1ns/1ns
`default_nettype none
`include "mgt_defines.svh"
module mgt_target (
    input  wire logic              clk,        // System clock, 250 MHz
    input  wire logic              rst,        // Synchronous reset, high
    input  wire mgt_pkg::mgt_bus_t bus_in,     // Raw clock and data lines
    output var  logic              sda_o,      // Data line drive level
    output var  logic              sda_oe_n,   // Low while pulling data low
    output var  logic [7:0]        rd_addr,    // Address counter value
    input  wire logic [7:0]        rd_data,    // Register byte at rd_addr
    output var  logic              rd_strobe,  // Byte taken for sending
    output var  mgt_pkg::mgt_wr_t  wr,         // Write address and data
    output var  logic              wr_valid,   // Write pulse
    output var  logic              busy        // Transaction in progress
);
    import mgt_pkg::*;

    mgt_bus_t   line_s;
    logic       scl_q_r;
    logic       sda_q_r;
    mgt_state_t state_r;
    mgt_state_t state_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic       rw_r;
    logic       rw_nxt;
    logic       mack_r;
    logic       mack_nxt;
    logic       oe_n_r;
    logic       oe_n_nxt;
    logic       rd_stb_r;
    logic       rd_stb_nxt;
    mgt_wr_t    wr_r;
    mgt_wr_t    wr_nxt;
    logic       wr_vld_r;
    logic       wr_vld_nxt;
    logic       busy_r;
    logic       sda_o_r;
    wire [7:0]  step_addr;
    wire        step_wr;

    // Line inputs are asynchronous; at 250 MHz even a 400 kHz clock
    // leaves hundreds of samples per half period
    mgt_sync u_sync (                                   // see RULE_01
        .clk  (clk),
        .rst  (rst),
        .pin  (bus_in),
        .sync (line_s)
    );

    // Next address within the wrapping sets
    mgt_addr_step u_step (
        .addr     (addr_r),
        .nxt      (step_addr),
        .writable (step_wr)
    );

    // Previous synchronised levels for edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= line_s.scl;
            sda_q_r <= line_s.sda;
        end
    end

    // Edge and condition decode
    wire scl_rise  = line_s.scl & ~scl_q_r;
    wire scl_fall  = ~line_s.scl & scl_q_r;
    wire scl_hi    = line_s.scl & scl_q_r;
    // Data moving with the clock high is framing, never a data bit
    wire cond_start = scl_hi & sda_q_r & ~line_s.sda;   // see RULE_05, RULE_06
    wire cond_stop  = scl_hi & ~sda_q_r & line_s.sda;   // see RULE_05, RULE_06
    wire byte_done  = scl_fall & (cnt_r == `MGT_BYTE_BITS);
    wire dev_match  = (sh_r[7:1] == `MGT_DEV_ADDR);     // see RULE_03
    wire dir_read   = sh_r[0];                          // see RULE_04
    wire [3:0] cnt_inc = cnt_r + `MGT_CNT_ONE;
    wire in_rx = (state_r == MGT_DEVADR) | (state_r == MGT_REGADR)
               | (state_r == MGT_WDATA);
    // A byte leaves for the controller on the fall closing an ack slot
    wire load_rd = scl_fall & (((state_r == MGT_ACK_DEV) & rw_r)
                 | ((state_r == MGT_RACK) & mack_r));

    // Protocol sequencing
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        sh_nxt     = sh_r;
        addr_nxt   = addr_r;
        rw_nxt     = rw_r;
        mack_nxt   = mack_r;
        oe_n_nxt   = oe_n_r;
        rd_stb_nxt = 1'b0;
        wr_nxt     = wr_r;
        wr_vld_nxt = 1'b0;
        if (cond_stop) begin
            // Stop ends any transfer and frees the line
            state_nxt = MGT_IDLE;                       // see RULE_06, RULE_13
            oe_n_nxt  = 1'b1;
        end else if (cond_start) begin
            // Start and repeated start both restart address matching
            state_nxt = MGT_DEVADR;                     // see RULE_02, RULE_17
            cnt_nxt   = `MGT_CNT_ZERO;
            oe_n_nxt  = 1'b1;
        end else if (load_rd) begin
            // Send the counter's byte, MSB first, then step the counter
            state_nxt  = MGT_RDATA;                     // see RULE_16, RULE_18
            sh_nxt     = rd_data;
            oe_n_nxt   = rd_data[7];
            rd_stb_nxt = 1'b1;
            addr_nxt   = step_addr;                     // see RULE_15
            cnt_nxt    = `MGT_CNT_ZERO;
        end else begin
            if (in_rx && scl_rise) begin
                // Bits are taken on the rising clock, MSB first
                sh_nxt  = {sh_r[6:0], line_s.sda};      // see RULE_08, RULE_09
                cnt_nxt = cnt_inc;
            end
            case (state_r)
                MGT_IDLE: begin
                    oe_n_nxt = 1'b1;
                end
                MGT_DEVADR: begin
                    if (byte_done) begin
                        cnt_nxt = `MGT_CNT_ZERO;
                        if (dev_match) begin
                            state_nxt = MGT_ACK_DEV;    // see RULE_02
                            oe_n_nxt  = 1'b0;           // see RULE_07
                            rw_nxt    = dir_read;       // see RULE_04
                        end else begin
                            // Other targets' traffic: stay off the line
                            state_nxt = MGT_IDLE;       // see RULE_02
                        end
                    end
                end
                MGT_REGADR: begin
                    if (byte_done) begin
                        state_nxt = MGT_ACK_REG;
                        cnt_nxt   = `MGT_CNT_ZERO;
                        addr_nxt  = sh_r;               // see RULE_08, RULE_17
                        oe_n_nxt  = 1'b0;               // see RULE_07
                    end
                end
                MGT_WDATA: begin
                    if (byte_done) begin
                        state_nxt = MGT_ACK_WR;
                        cnt_nxt   = `MGT_CNT_ZERO;
                        oe_n_nxt  = 1'b0;               // see RULE_09, RULE_12
                        addr_nxt  = step_addr;          // see RULE_10, RULE_11
                        // Read-only and unmapped bytes are acked, not stored
                        if (step_wr) begin
                            wr_vld_nxt = 1'b1;          // see RULE_12, RULE_21
                            wr_nxt     = '{addr: addr_r, data: sh_r};
                        end
                    end
                end
                MGT_ACK_DEV: begin
                    // Reads leave through load_rd; writes await an address
                    if (scl_fall) begin
                        state_nxt = MGT_REGADR;
                        oe_n_nxt  = 1'b1;
                    end
                end
                MGT_ACK_REG, MGT_ACK_WR: begin
                    if (scl_fall) begin
                        state_nxt = MGT_WDATA;          // see RULE_09
                        oe_n_nxt  = 1'b1;
                    end
                end
                MGT_RDATA: begin
                    // Output bits only change on the falling clock
                    if (scl_fall) begin                 // see RULE_05
                        if (cnt_r == `MGT_BIT_LAST) begin
                            state_nxt = MGT_RACK;
                            oe_n_nxt  = 1'b1;           // see RULE_07, RULE_14
                        end else begin
                            sh_nxt   = {sh_r[6:0], 1'b0};
                            oe_n_nxt = sh_r[6];
                            cnt_nxt  = cnt_inc;
                        end
                    end
                end
                MGT_RACK: begin
                    if (scl_rise) begin
                        mack_nxt = ~line_s.sda;         // see RULE_14
                    end
                    // No ack: stop sending and wait for the stop
                    if (scl_fall && !mack_r) begin
                        state_nxt = MGT_IDLE;           // see RULE_14, RULE_19
                        oe_n_nxt  = 1'b1;
                    end
                end
                default: begin
                    state_nxt = MGT_IDLE;
                    oe_n_nxt  = 1'b1;
                end
            endcase
        end
    end

    // Sequencing state
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= MGT_IDLE;
            cnt_r   <= `MGT_CNT_ZERO;
            sh_r    <= `MGT_ADDR_RST;
            rw_r    <= 1'b0;
            mack_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            sh_r    <= sh_nxt;
            rw_r    <= rw_nxt;
            mack_r  <= mack_nxt;
        end
    end

    // Address counter survives between transactions for current reads
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_r <= `MGT_ADDR_RST;
        end else begin
            addr_r <= addr_nxt;                         // see RULE_15
        end
    end

    // Registered outputs; the drive level is always low, only enable moves
    always_ff @(posedge clk) begin
        if (rst) begin
            oe_n_r   <= 1'b1;
            rd_stb_r <= 1'b0;
            wr_r     <= '0;
            wr_vld_r <= 1'b0;
            busy_r   <= 1'b0;
            sda_o_r  <= 1'b0;
        end else begin
            oe_n_r   <= oe_n_nxt;
            rd_stb_r <= rd_stb_nxt;
            wr_r     <= wr_nxt;
            wr_vld_r <= wr_vld_nxt;
            busy_r   <= (state_nxt != MGT_IDLE);
            sda_o_r  <= 1'b0;
        end
    end

    // Port hookup
    assign sda_o     = sda_o_r;
    assign sda_oe_n  = oe_n_r;
    assign rd_addr   = addr_r;
    assign rd_strobe = rd_stb_r;
    assign wr        = wr_r;
    assign wr_valid  = wr_vld_r;
    assign busy      = busy_r;
endmodule : mgt_target
`default_nettype wire

/* mgt_defines.svh */
// Constants of the magnetometer two-wire target port
// Summary of operation
// RULE_01: Port works at bus clocks up to 100 kHz standard, 400 kHz fast.
// RULE_02: After start, compare address byte; acknowledge only on match, then serve.
// RULE_03: Fixed 7-bit target address is 0Ch.
// RULE_04: Last bit of first byte: 1 means read, 0 means write.
// RULE_05: Data changes only while clock low, except start and stop.
// RULE_06: Data fall with clock high is start; rise is stop.
// RULE_07: Transmitter releases data after each byte; receiver pulls low to acknowledge.
// RULE_08: In a write, the second byte is the register address, acknowledged.
// RULE_09: Third and later write bytes are data, MSB first, each acknowledged.
// RULE_10: Low set steps 00,01,02,03,10..18, wrapping 18 to 00.
// RULE_11: High set steps 30 to 32, wrapping 32 to 30.
// RULE_12: Only read/write locations take write data; others acknowledged, no effect.
// RULE_13: Controller ends every write with a stop.
// RULE_14: In a read, sample acknowledge; on ack send next byte, else stop.
// RULE_15: Counter holds address after the last one accessed.
// RULE_16: Current read: ack address, send counter's byte, then increment counter.
// RULE_17: Random read: dummy write of register address, repeated start, read.
// RULE_18: Random read sends byte at dummy-write address, then increments counter.
// RULE_19: Controller withholds acknowledge on last byte and sends stop.
// RULE_20: Self-test passes when X,Y in -200..200 and Z in -1000..-150.
// RULE_21: Unmapped addresses read harmlessly and ignore writes, protocol unaffected.
`ifndef MGT_DEFINES_SVH
`define MGT_DEFINES_SVH
`define MGT_DEV_ADDR   7'h0c
`define MGT_ADDR_RST   8'h00
`define MGT_LO_GAP     8'h03
`define MGT_LO_RESUME  8'h10
`define MGT_LO_END     8'h18
`define MGT_HI_BASE    8'h30
`define MGT_HI_END     8'h32
`define MGT_ADDR_ONE   8'h01
`define MGT_CNT_ZERO   4'h0
`define MGT_CNT_ONE    4'h1
`define MGT_BIT_LAST   4'h7
`define MGT_BYTE_BITS  4'h8
`define MGT_CLK_KHZ    250000
`define MGT_FAST_KHZ   400
`define MGT_STD_KHZ    100
`define MGT_HALF_CYC   (`MGT_CLK_KHZ / `MGT_FAST_KHZ / 2)
`endif

/* mgt_pkg.sv */
// Types shared by the magnetometer two-wire target port
package mgt_pkg;
    // Sampled levels of the two bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } mgt_bus_t;
    // One accepted register write
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } mgt_wr_t;
    // Protocol states, one-hot
    typedef enum logic [8:0] {
        MGT_IDLE    = 9'h001,
        MGT_DEVADR  = 9'h002,
        MGT_ACK_DEV = 9'h004,
        MGT_REGADR  = 9'h008,
        MGT_ACK_REG = 9'h010,
        MGT_WDATA   = 9'h020,
        MGT_ACK_WR  = 9'h040,
        MGT_RDATA   = 9'h080,
        MGT_RACK    = 9'h100
    } mgt_state_t;
endpackage : mgt_pkg

/* mgt_sync.sv */
// Two-flop synchronisers for the bus line inputs
`timescale 1ns/1ns
`default_nettype none
module mgt_sync (
    input  wire logic            clk,    // System clock
    input  wire logic            rst,    // Synchronous reset, high
    input  wire mgt_pkg::mgt_bus_t pin,  // Raw line levels
    output var  mgt_pkg::mgt_bus_t sync  // Synchronised levels
);
    import mgt_pkg::*;
    logic [1:0] meta_r;
    logic [1:0] hold_r;
    // Idle lines are pulled high, so reset to high avoids a false start
    for (genvar i = 0; i < 2; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (rst) begin
                meta_r[i] <= 1'b1;
                hold_r[i] <= 1'b1;
            end else begin
                meta_r[i] <= pin[i];
                hold_r[i] <= meta_r[i];
            end
        end
    end
    assign sync = hold_r;
endmodule : mgt_sync
`default_nettype wire

/* mgt_addr_step.sv */
// Address counter stepping through the two wrapping address sets
`timescale 1ns/1ns
`default_nettype none
`include "mgt_defines.svh"
module mgt_addr_step (
    input  wire logic [7:0] addr,     // Current counter value
    output wire logic [7:0] nxt,      // Counter after one byte
    output wire logic       writable  // Location takes write data
);
    wire in_lo   = (addr <= `MGT_LO_END);
    wire in_hi   = (addr >= `MGT_HI_BASE) && (addr <= `MGT_HI_END);
    wire [7:0] inc = addr + `MGT_ADDR_ONE;
    wire [7:0] lo_nxt = (addr == `MGT_LO_GAP) ? `MGT_LO_RESUME :   // see RULE_10
                        (addr == `MGT_LO_END) ? `MGT_ADDR_RST : inc; // see RULE_10
    wire [7:0] hi_nxt = (addr == `MGT_HI_END) ? `MGT_HI_BASE : inc; // see RULE_11
    // Outside both sets just count on; nothing there is stored
    assign nxt      = in_lo ? lo_nxt : (in_hi ? hi_nxt : inc);      // see RULE_21
    assign writable = in_hi;                                        // see RULE_12
endmodule : mgt_addr_step
`default_nettype wire

/* mgt_target_asserts.sv */
// Protocol checker of the two-wire target port
`timescale 1ns/1ns
`default_nettype none
module mgt_asserts (
    input wire logic              clk,       // Clock
    input wire logic              rst,       // Reset
    input wire mgt_pkg::mgt_bus_t bus_in,    // Raw lines
    input wire logic              sda_o,     // Drive level
    input wire logic              sda_oe_n,  // Pull, low
    input wire logic [7:0]        rd_addr,   // Counter
    input wire logic [7:0]        rd_data,   // Read byte
    input wire logic              rd_strobe, // Byte taken
    input wire mgt_pkg::mgt_wr_t  wr,        // Write word
    input wire logic              wr_valid,  // Write pulse
    input wire logic              busy       // Busy
);
    import mgt_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Counter step; the gaps and wraps are where a plain +1 fails
    function automatic logic [7:0] step(input logic [7:0] v);
        case (v)
            8'h03: step = 8'h10;
            8'h18: step = 8'h00;
            8'h32: step = 8'h30;
            default: step = v + 8'h01;
        endcase
    endfunction : step
    // Framing seen on the raw lines with the clock high twice
    sequence s_start;
        bus_in.scl && $past(bus_in.scl) && $fell(bus_in.sda);
    endsequence
    sequence s_stop;
        bus_in.scl && $past(bus_in.scl) && $rose(bus_in.sda);
    endsequence
    // Line handling and framing
    a_edge_low: assert property ($changed(sda_oe_n) |-> !bus_in.scl)
        else $error("data moved with clock high");
    a_start_busy: assert property (s_start |-> ##[1:8] busy)
        else $error("start not taken");
    a_stop_idle: assert property (s_stop |-> ##[1:8] !busy)
        else $error("stop not taken");
    a_idle_free: assert property (!busy && $past(!busy) |-> sda_oe_n)
        else $error("line pulled while idle");
    // Writes and the address counter
    a_wr_place: assert property (wr_valid |-> busy && wr.addr inside {[8'h30:8'h32]})
        else $error("write outside control set");
    a_wr_step: assert property (wr_valid |-> rd_addr == step(wr.addr))
        else $error("counter not stepped on write");
    a_wr_once: assert property (wr_valid |=> !wr_valid)
        else $error("write pulse too long");
    a_rd_step: assert property (rd_strobe |-> rd_addr == step($past(rd_addr, 2)))
        else $error("counter not stepped on read");
endmodule : mgt_asserts
bind mgt_target mgt_asserts u_chk (
    .clk(clk), .rst(rst), .bus_in(bus_in), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_strobe(rd_strobe), .wr(wr),
    .wr_valid(wr_valid), .busy(busy)
);
`default_nettype wire

/* mgt_host.sv */
// Bus controller model driving the clock and data lines
`timescale 1ns/1ns
`default_nettype none
module mgt_host (
    input  wire logic              clk,   // Clock
    input  wire logic              sda_w, // Resolved data
    output var  mgt_pkg::mgt_bus_t lines  // Driven lines
);
    import mgt_pkg::*;
    initial lines = 2'b11;
    // Ten clocks, about a third of a bit; 31 clocks a bit is close to the 125 ns link period
    task automatic q;
        repeat (10) @(posedge clk);
    endtask : q
    // Data moves with the clock high: a,b = 1,0 start, 0,1 stop
    task automatic frame(input logic a, input logic b);
        lines.sda <= a;
        q();
        lines.scl <= 1'b1;
        q();
        lines.sda <= b;
        q();
        if (!b) begin
            lines.scl <= 1'b0;
            q();
        end
    endtask : frame
    // One bit, sampled mid high phase, changed only with clock low
    task automatic slot(input logic b, output logic s);
        lines.sda <= b;
        q();
        lines.scl <= 1'b1;
        repeat (5) @(posedge clk);
        s = sda_w;
        repeat (6) @(posedge clk);
        lines.scl <= 1'b0;
        q();
    endtask : slot
    // Byte MSB first, then the acknowledge slot; 1 releases the line
    task automatic xfer(input logic [7:0] d, input logic k,
                        output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) begin
            slot(d[i], r[i]);
        end
        slot(k, a);
    endtask : xfer
    // Host verdict on self-test counts; the limits include both ends
    function automatic logic st_ok(input logic signed [15:0] x_axis_result,
                                   input logic signed [15:0] y_axis_result,
                                   input logic signed [15:0] z_axis_result);
        st_ok = (x_axis_result >= -16'sd200) && (x_axis_result <= 16'sd200)
             && (y_axis_result >= -16'sd200) && (y_axis_result <= 16'sd200)
             && (z_axis_result >= -16'sd1000) && (z_axis_result <= -16'sd150);
    endfunction : st_ok
endmodule : mgt_host
`default_nettype wire

/* mgt_target_tb.sv */
// Self-checking bench of the two-wire target port
`timescale 1ns/1ns
`default_nettype none
module mgt_target_tb;
    import mgt_pkg::*;
    // Write row: register, data, counter after, write pulse expected
    typedef struct packed {
        logic [7:0] ra;
        logic [7:0] d;
        logic [7:0] nx;
        logic       w;
    } mgt_row_t;
    localparam mgt_row_t rows [7] = '{
        '{8'h30, 8'ha1, 8'h31, 1'b1}, '{8'h31, 8'hb2, 8'h32, 1'b1},
        '{8'h32, 8'hc3, 8'h30, 1'b1}, '{8'h03, 8'h11, 8'h10, 1'b0},
        '{8'h18, 8'h22, 8'h00, 1'b0}, '{8'h10, 8'h33, 8'h11, 1'b0},
        '{8'h40, 8'h44, 8'h41, 1'b0}};
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic           sda_o, sda_oe_n, rd_strobe, wr_valid, busy, a;
    logic [7:0]     rd_addr, r, n0;
    logic [7:0]     wv_cnt = 8'h00;
    logic [7:0]     rs_cnt = 8'h00;
    mgt_bus_t       lines;
    mgt_wr_t        wr, wr_seen;
    int             errors = 0;
    int             check_count = 0;
    // Open-drain line with pull-up; register file reads addr^5a
    wire logic       sda_w = lines.sda & (sda_oe_n | sda_o);
    wire mgt_bus_t   bus_w = {lines.scl, sda_w};
    wire logic [7:0] rd_data = rd_addr ^ 8'h5a;
    always #2 clk = ~clk;
    mgt_target u_dut (.clk(clk), .rst(rst), .bus_in(bus_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_strobe(rd_strobe), .wr(wr), .wr_valid(wr_valid), .busy(busy));
    mgt_host u_host (.clk(clk), .sda_w(sda_w), .lines(lines));
    // Count write pulses and keep the last word
    always @(posedge clk) begin
        if (wr_valid === 1'b1) begin
            wv_cnt <= wv_cnt + 8'h01;
            wr_seen <= wr;
        end
        if (rd_strobe === 1'b1) begin
            rs_cnt <= rs_cnt + 8'h01;
        end
    end
    task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic wrap_up;
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    // Bounded wait for the port to drop busy after a stop
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        check("busy", {7'h00, busy}, 8'h00);
        if (n == 40) begin
            wrap_up();
        end
    endtask : wait_idle
    task automatic put(input logic [7:0] d);
        u_host.xfer(d, 1'b1, r, a);
        check("ack", {7'h00, a}, 8'h00);
    endtask : put
    task automatic get(input logic k, input logic [7:0] e);
        u_host.xfer(8'hff, k, r, a);
        check("read byte", r, e);
    endtask : get
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        check("reset addr", rd_addr, 8'h00);
        // Single writes across both address sets and unmapped space
        foreach (rows[i]) begin
            n0 = wv_cnt;
            u_host.frame(1'b1, 1'b0);
            put(8'h18);
            put(rows[i].ra);
            put(rows[i].d);
            u_host.frame(1'b0, 1'b1);
            wait_idle();
            check("writes", wv_cnt - n0, {7'h00, rows[i].w});
            check("next addr", rd_addr, rows[i].nx);
            if (rows[i].w) begin
                check("wr addr", wr_seen.addr, rows[i].ra);
                check("wr data", wr_seen.data, rows[i].d);
            end
        end
        // Foreign address is not acknowledged
        u_host.frame(1'b1, 1'b0);
        u_host.xfer(8'h1a, 1'b1, r, a);
        check("nack", {7'h00, a}, 8'h01);
        u_host.frame(1'b0, 1'b1);
        wait_idle();
        // Burst write wrapping inside the control set
        n0 = wv_cnt;
        u_host.frame(1'b1, 1'b0);
        put(8'h18);
        put(8'h31);
        put(8'hd1);
        put(8'hd2);
        put(8'hd3);
        u_host.frame(1'b0, 1'b1);
        wait_idle();
        check("burst", wv_cnt - n0, 8'h03);
        check("burst addr", wr_seen.addr, 8'h30);
        check("burst data", wr_seen.data, 8'hd3);
        // Random read over the low set wrap, then a current read
        n0 = rs_cnt;
        u_host.frame(1'b1, 1'b0);
        put(8'h18);
        put(8'h17);
        u_host.frame(1'b1, 1'b0);
        put(8'h19);
        get(1'b0, 8'h17 ^ 8'h5a);
        get(1'b1, 8'h18 ^ 8'h5a);
        u_host.frame(1'b0, 1'b1);
        wait_idle();
        check("after random", rd_addr, 8'h00);
        check("read strobes", rs_cnt - n0, 8'h02);
        u_host.frame(1'b1, 1'b0);
        put(8'h19);
        get(1'b1, 8'h00 ^ 8'h5a);
        u_host.frame(1'b0, 1'b1);
        wait_idle();
        check("after current", rd_addr, 8'h01);
        // Reset in mid transfer drops the port back to idle
        u_host.frame(1'b1, 1'b0);
        put(8'h18);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check("rst addr", rd_addr, 8'h00);
        check("rst busy", {7'h00, busy}, 8'h00);
        check("rst line", {7'h00, sda_oe_n}, 8'h01);
        check("drive lvl", {7'h00, sda_o}, 8'h00);
        u_host.frame(1'b0, 1'b1);
        wait_idle();
        // Host self-test verdict at and just past the limits
        check("st in", {7'h00, u_host.st_ok(16'sd200, -16'sd200, -16'sd150)}, 8'h01);
        check("st x", {7'h00, u_host.st_ok(16'sd201, 16'sd0, -16'sd500)}, 8'h00);
        check("st y", {7'h00, u_host.st_ok(16'sd0, -16'sd201, -16'sd1000)}, 8'h00);
        check("st zhi", {7'h00, u_host.st_ok(16'sd0, 16'sd0, -16'sd149)}, 8'h00);
        check("st zlo", {7'h00, u_host.st_ok(16'sd0, 16'sd0, -16'sd1001)}, 8'h00);
        wrap_up();
    end
endmodule : mgt_target_tb
`default_nettype wire
